// ===== design/msi_alu.sv
/*
  multiply-low (signed x unsigned) and 16-bit increment execution slice,
  with its operands, product, flags and repeat count held in registers
  reached over AXI4-Lite. assumes the bus master keeps one write and one
  read outstanding at most and that all inputs are synchronous to i_clk.
  // Operation
  // - multiplicand signed, memory operand unsigned
  // - keep low 38 product bits, mode picks slice
  // - left four: temp 27..0 to 31..4, zero low
  // - left one: temp 30..0 to 31..1, zero bit0
  // - zero shift copies temp 31..0 unchanged
  // - right n loads temp 31+n down to n
  // - multiply opcode, object mode one, single cycle
  // - after repeat prefix clear count, run once
  // - zero flag set when result is zero
  // - carry set on carry out, else cleared
  // - overflow set on overflow, else unchanged
*/
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module msi_alu (
  input  wire logic        i_clk,     // core clock, 10 MHz
  input  wire logic        i_rst_n,   // async reset, active low
  input  wire logic [7:0]  i_awaddr,  // write address
  input  wire logic        i_awvalid, // write address valid
  output logic             o_awready, // write address ready
  input  wire logic [31:0] i_wdata,   // write data
  input  wire logic [3:0]  i_wstrb,   // write byte strobes
  input  wire logic        i_wvalid,  // write data valid
  output logic             o_wready,  // write data ready
  output logic [1:0]       o_bresp,   // write response
  output logic             o_bvalid,  // write response valid
  input  wire logic        i_bready,  // write response ready
  input  wire logic [7:0]  i_araddr,  // read address
  input  wire logic        i_arvalid, // read address valid
  output logic             o_arready, // read address ready
  output logic [31:0]      o_rdata,   // read data
  output logic [1:0]       o_rresp,   // read response
  output logic             o_rvalid,  // read data valid
  input  wire logic        i_rready   // read data ready
);
  import msi_pkg::*;

  // architectural state
  logic [31:0] mcand_r;    // multiplicand_reg
  logic [31:0] oplong_r;   // operand_location_long
  logic [15:0] opshort_r;  // operand_location_short
  logic [3:0]  pm_r;       // product_shift_mode
  logic        object_mode_bit_r;  // object_mode_bit
  logic [15:0] rpt_r;      // repeat_count
  logic [31:0] product_r;  // product register
  logic [31:0] acc_r;      // accumulator, software owned
  msi_flags_s  flags_r;    // n z c v
  logic        ill_r;      // sticky illegal issue

  // bus write decode
  logic        wr_go;      // address and data taken together
  logic [31:0] wmask;      // byte strobes widened to bits
  logic        wr_hit;     // write address is mapped
  logic        mul_go;     // legal multiply issued this cycle
  logic        inc_go;     // increment issued this cycle
  logic        ill_go;     // multiply issued outside object mode 1

  // both channels are taken in one beat so the order never matters
  assign wr_go     = i_awvalid && i_wvalid && !o_bvalid;
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign wmask     = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
                      {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};

  // address decode for writes
  always_comb begin
    case (i_awaddr)
      MSI_OFS_MCAND, MSI_OFS_OPLONG, MSI_OFS_OPSHORT, MSI_OFS_MODE,
      MSI_OFS_REPEAT, MSI_OFS_ISSUE, MSI_OFS_FLAGS, MSI_OFS_ACC: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0; // product is read only, rest unmapped
      end
    endcase
  end

  // instruction issue: the opcode word written to the issue port
  logic issue_wr; // write to the issue port
  assign issue_wr = wr_go && (i_awaddr == MSI_OFS_ISSUE);
  assign mul_go   = issue_wr && (i_wdata[15:0] == MSI_OPC_MUL)
                    && object_mode_bit_r;
  assign ill_go   = issue_wr && (i_wdata[15:0] == MSI_OPC_MUL)
                    && !object_mode_bit_r;
  assign inc_go   = issue_wr && (i_wdata[15:8] == MSI_OPC_INC_HI);

  // multiply datapath, settled within the issuing cycle
  logic signed [64:0] full_prod; // exact signed x unsigned product
  logic [37:0]        temp;      // low 38 bits kept
  logic [37:0]        temp_shr;  // temp moved right by the mode
  logic [3:0]         rshift;    // right shift distance
  logic [31:0]        product_nxt;

  // zero-extending the operand makes it unsigned inside a signed multiply
  assign full_prod = $signed(mcand_r) * $signed({1'b0, oplong_r});
  assign temp      = full_prod[37:0];
  assign rshift    = pm_r - MSI_PM_RIGHT_BASE;
  assign temp_shr  = temp >> rshift;

  // slice selection by product_shift_mode
  always_comb begin
    case (pm_r)
      MSI_PM_LEFT4: begin
        product_nxt = {temp[27:0], 4'h0};
      end
      MSI_PM_LEFT1: begin
        product_nxt = {temp[30:0], 1'b0};
      end
      MSI_PM_RIGHT1, MSI_PM_RIGHT2, MSI_PM_RIGHT3,
      MSI_PM_RIGHT4, MSI_PM_RIGHT5, MSI_PM_RIGHT6: begin
        product_nxt = temp_shr[31:0];
      end
      default: begin
        product_nxt = temp[31:0]; // unused codes act as zero shift
      end
    endcase
  end

  // increment datapath
  logic [16:0] inc_sum; // carry in bit 16
  assign inc_sum = {1'b0, opshort_r} + 17'h0_0001;

  // software registers with strobes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mcand_r   <= MSI_RST_WORD;
      oplong_r  <= MSI_RST_WORD;
      pm_r      <= MSI_PM_ZERO;
      object_mode_bit_r <= 1'b0;
      acc_r     <= MSI_RST_WORD;
    end else if (wr_go) begin
      case (i_awaddr)
        MSI_OFS_MCAND: begin
          mcand_r <= (mcand_r & ~wmask) | (i_wdata & wmask);
        end
        MSI_OFS_OPLONG: begin
          oplong_r <= (oplong_r & ~wmask) | (i_wdata & wmask);
        end
        MSI_OFS_MODE: begin
          if (i_wstrb[0]) begin
            pm_r <= i_wdata[MSI_MODE_PM_LSB +: 4];
          end
          if (i_wstrb[1]) begin
            object_mode_bit_r <= i_wdata[MSI_MODE_OBJ_BIT];
          end
        end
        MSI_OFS_ACC: begin
          acc_r <= (acc_r & ~wmask) | (i_wdata & wmask);
        end
        default: begin
          // other offsets handled elsewhere
        end
      endcase
    end
  end

  // short operand: software load or increment write-back
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opshort_r <= MSI_RST_SHORT;
    end else if (inc_go) begin
      opshort_r <= inc_sum[15:0];
    end else if (wr_go && i_awaddr == MSI_OFS_OPSHORT) begin
      opshort_r <= (opshort_r & ~wmask[15:0]) | (i_wdata[15:0] & wmask[15:0]);
    end
  end

  // product register, changed by the multiply alone, in one cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      product_r <= MSI_RST_WORD;
    end else if (mul_go) begin
      product_r <= product_nxt;
    end
  end

  // repeat count: a repeat prefix loads it, these instructions clear it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rpt_r <= MSI_RST_RPT;
    end else if (mul_go || inc_go) begin
      rpt_r <= MSI_RST_RPT; // not repeatable: run once
    end else if (wr_go && i_awaddr == MSI_OFS_REPEAT) begin
      rpt_r <= (rpt_r & ~wmask[15:0]) | (i_wdata[15:0] & wmask[15:0]);
    end
  end

  // flags: increment updates, multiply leaves them alone
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_r <= '0;
    end else if (inc_go) begin
      flags_r.n <= inc_sum[15];
      flags_r.z <= (inc_sum[15:0] == '0);
      flags_r.c <= inc_sum[16];
      if (opshort_r == MSI_SHORT_MAX_P) begin
        flags_r.v <= 1'b1;
      end
    end else if (wr_go && i_awaddr == MSI_OFS_FLAGS && i_wstrb[0]) begin
      flags_r <= i_wdata[MSI_FLG_V_BIT:MSI_FLG_N_BIT];
    end
  end

  // illegal issue flag: set beats a write-one clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ill_r <= 1'b0;
    end else if (ill_go) begin
      ill_r <= 1'b1; // rejected outside object mode 1
    end else if (wr_go && i_awaddr == MSI_OFS_FLAGS && i_wstrb[0]
                 && i_wdata[MSI_FLG_ILL_BIT]) begin
      ill_r <= 1'b0;
    end
  end

  // write response, one cycle after the beat
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= MSI_RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_hit ? MSI_RESP_OKAY : MSI_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // read path: mux then register
  logic [31:0] rd_mux; // selected word
  logic        rd_hit; // read address mapped
  assign o_arready = !o_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    case (i_araddr)
      MSI_OFS_MCAND:   rd_mux = mcand_r;
      MSI_OFS_OPLONG:  rd_mux = oplong_r;
      MSI_OFS_OPSHORT: rd_mux = {16'h0000, opshort_r};
      MSI_OFS_MODE:    rd_mux = {23'h00_0000, object_mode_bit_r, 4'h0, pm_r};
      MSI_OFS_REPEAT:  rd_mux = {16'h0000, rpt_r};
      MSI_OFS_ISSUE:   rd_mux = MSI_RST_WORD; // write only port
      MSI_OFS_PRODUCT: rd_mux = product_r;
      MSI_OFS_FLAGS:   rd_mux = {27'h000_0000, ill_r, flags_r};
      MSI_OFS_ACC:     rd_mux = acc_r;
      default: begin
        rd_mux = MSI_RST_WORD;
        rd_hit = 1'b0; // unmapped reads zero with an error
      end
    endcase
  end

  // read data held until the master takes it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= MSI_RST_WORD;
      o_rresp  <= MSI_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_hit ? MSI_RESP_OKAY : MSI_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // checks on the datapath, sampled on the core clock
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_mul_sign;
    mul_go && mcand_r[31] && oplong_r != 32'h0000_0000 |->
      full_prod[64];
  endproperty
  a_mul_sign: assert property (p_mul_sign)
    else $error("multiply did not treat operands as signed x unsigned");

  property p_right6_top;
    mul_go && pm_r == MSI_PM_RIGHT6 |=> product_r[31] == $past(temp[37]);
  endproperty
  a_right6_top: assert property (p_right6_top)
    else $error("bit 37 of the kept product not at the top");

  property p_left4;
    mul_go && pm_r == MSI_PM_LEFT4 |=>
      product_r == {$past(full_prod[27:0]), 4'h0};
  endproperty
  a_left4: assert property (p_left4)
    else $error("left four slice wrong");

  property p_left1;
    mul_go && pm_r == MSI_PM_LEFT1 |=>
      product_r[0] == 1'b0 && product_r[31:1] == $past(full_prod[30:0]);
  endproperty
  a_left1: assert property (p_left1)
    else $error("left one slice wrong");

  property p_zero;
    mul_go && pm_r == MSI_PM_ZERO |=> product_r == $past(full_prod[31:0]);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero shift slice wrong");

  property p_right2;
    mul_go && pm_r == MSI_PM_RIGHT2 |=> product_r == $past(full_prod[33:2]);
  endproperty
  a_right2: assert property (p_right2)
    else $error("right two slice wrong");

  property p_object_mode_bit;
    issue_wr && i_wdata[15:0] == MSI_OPC_MUL && !object_mode_bit_r |=>
      $stable(product_r) && ill_r;
  endproperty
  a_object_mode_bit: assert property (p_object_mode_bit)
    else $error("multiply ran outside object mode 1");

  property p_repeat;
    (mul_go || inc_go) |=> rpt_r == 16'h0000 ##1 $stable(opshort_r);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat count not cleared or instruction repeated");

  property p_inc;
    inc_go |=> opshort_r == 16'($past(opshort_r) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment write-back wrong");

  property p_flag_nz;
    inc_go |=> flags_r.n == opshort_r[15]
      && flags_r.z == (opshort_r == 16'h0000);
  endproperty
  a_flag_nz: assert property (p_flag_nz)
    else $error("negative or zero flag wrong after increment");

  property p_carry;
    inc_go |=> flags_r.c == ($past(opshort_r) == MSI_SHORT_ONES);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong after increment");

  property p_ovf;
    inc_go |=> flags_r.v == ($past(flags_r.v)
      || $past(opshort_r) == MSI_SHORT_MAX_P);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag wrong after increment");

  property p_mul_only;
    mul_go |=> $stable(flags_r) && $stable(acc_r) && $stable(opshort_r);
  endproperty
  a_mul_only: assert property (p_mul_only)
    else $error("multiply disturbed state other than the product");

  c_mul_right: cover property (mul_go && pm_r == MSI_PM_RIGHT3);
  c_inc_ovf:   cover property (inc_go && opshort_r == MSI_SHORT_MAX_P);
  c_inc_wrap:  cover property (inc_go && opshort_r == MSI_SHORT_ONES);
  c_rpt_clear: cover property (rpt_r != 16'h0000 ##1 mul_go);

endmodule

// ===== design/msi_pkg.sv
/*
  package for the multiply/increment execution slice: register offsets,
  field positions, reset values, opcode patterns, shift mode codes and the
  flag carrier. assumes a 32-bit AXI4-Lite register bus with word offsets.
*/
package msi_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] MSI_OFS_MCAND   = 8'h00; // multiplicand_reg
  localparam logic [7:0] MSI_OFS_OPLONG  = 8'h04; // operand_location_long
  localparam logic [7:0] MSI_OFS_OPSHORT = 8'h08; // operand_location_short
  localparam logic [7:0] MSI_OFS_MODE    = 8'h0C; // shift mode, object mode
  localparam logic [7:0] MSI_OFS_REPEAT  = 8'h10; // repeat_count
  localparam logic [7:0] MSI_OFS_ISSUE   = 8'h14; // opcode issue port
  localparam logic [7:0] MSI_OFS_PRODUCT = 8'h18; // product register
  localparam logic [7:0] MSI_OFS_FLAGS   = 8'h1C; // n z c v and illegal
  localparam logic [7:0] MSI_OFS_ACC     = 8'h20; // accumulator

  // field positions
  localparam int MSI_MODE_PM_LSB  = 0;  // product_shift_mode, 4 bits
  localparam int MSI_MODE_OBJ_BIT = 8;  // object_mode_bit
  localparam int MSI_FLG_N_BIT    = 0;
  localparam int MSI_FLG_Z_BIT    = 1;
  localparam int MSI_FLG_C_BIT    = 2;
  localparam int MSI_FLG_V_BIT    = 3;
  localparam int MSI_FLG_ILL_BIT  = 4;  // illegal issue, sticky

  // reset values
  localparam logic [31:0] MSI_RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] MSI_RST_SHORT = 16'h0000;
  localparam logic [15:0] MSI_RST_RPT   = 16'h0000;

  // opcode patterns on the issue port
  localparam logic [15:0] MSI_OPC_MUL     = 16'h5665; // whole word
  localparam logic [7:0]  MSI_OPC_INC_HI  = 8'h0A;    // high byte only
  localparam logic [15:0] MSI_SHORT_MAX_P = 16'h7FFF; // largest positive
  localparam logic [15:0] MSI_SHORT_ONES  = 16'hFFFF;

  // product shift mode codes
  typedef enum logic [3:0] {
    MSI_PM_ZERO   = 4'b0000,
    MSI_PM_LEFT1  = 4'b0001,
    MSI_PM_LEFT4  = 4'b0010,
    MSI_PM_RIGHT1 = 4'b0011,
    MSI_PM_RIGHT2 = 4'b0100,
    MSI_PM_RIGHT3 = 4'b0101,
    MSI_PM_RIGHT4 = 4'b0110,
    MSI_PM_RIGHT5 = 4'b0111,
    MSI_PM_RIGHT6 = 4'b1000
  } msi_pm_e;

  // offset from a right code to its shift distance
  localparam logic [3:0] MSI_PM_RIGHT_BASE = 4'b0010;

  // axi response codes
  localparam logic [1:0] MSI_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MSI_RESP_SLVERR = 2'b10;

  // status flags carried together
  typedef struct packed {
    logic v;
    logic c;
    logic z;
    logic n;
  } msi_flags_s;

endpackage

// ===== tb/msi_alu_tb.sv
/*
  self-checking bench for the multiply/increment slice: drives the
  AXI4-Lite port directly, notes expectations in queues, a monitor
  compares every response. assumes msi_pkg and msi_alu are compiled first.
*/
`timescale 1ns/1ps
module msi_alu_tb;
  import msi_pkg::*;

  // expected read answer; k says whether data is defined
  typedef struct packed {
    logic [31:0] d;
    logic [1:0]  r;
    logic        k;
  } msi_tb_exp_s;

  logic        i_clk, i_rst_n;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  msi_tb_exp_s rq[$];      // pending read expectations
  logic [1:0]  bq[$];      // pending write responses
  int          fail_count, checks, seed;

  msi_alu dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready)
  );

  // free-running core clock, 100 ns period
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a wait that runs dry counts as a mismatch and ends the run
  task automatic timeout();
    fail_count++;
    conclude();
  endtask

  // reference slice of the 38-bit temporary product
  function automatic logic [31:0] exp_prod(input logic [31:0] mc, op,
                                           input logic [3:0] pm);
    logic [63:0] f;
    logic [37:0] t;
    f = {{32{mc[31]}}, mc} * {32'h0000_0000, op};
    t = f[37:0];
    if (pm == 4'h1) return {t[30:0], 1'b0};
    if (pm == 4'h2) return {t[27:0], 4'h0};
    if (pm >= 4'h3 && pm <= 4'h8)
      return 32'(t >> (pm - MSI_PM_RIGHT_BASE));
    return t[31:0];
  endfunction

  // one write: address and data offered together, held until taken
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rsp);
    int n;
    bq.push_back(rsp);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_wstrb   <= 4'hF;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_awready !== 1'b1 && n < 50);
    if (o_awready !== 1'b1) timeout();
    check("wready", {31'h0, o_wready}, 32'h0000_0001);
    i_awvalid <= 1'b0;
    i_wvalid  <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_bvalid !== 1'b1 && n < 50);
    if (o_bvalid !== 1'b1) timeout();
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask

  // one read; the monitor compares the answer
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rsp, input logic k);
    int n;
    rq.push_back('{d: d, r: rsp, k: k});
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_arready !== 1'b1 && n < 50);
    if (o_arready !== 1'b1) timeout();
    i_arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_rvalid !== 1'b1 && n < 50);
    if (o_rvalid !== 1'b1) timeout();
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask

  // monitor: takes the oldest note whenever an answer is handed over
  always @(posedge i_clk) begin
    msi_tb_exp_s e;
    if (o_bvalid === 1'b1 && i_bready === 1'b1) begin
      if (bq.size() == 0)
        check("bresp unexpected", 32'h0000_0001, 32'h0000_0000);
      else
        check("bresp", {30'h0, o_bresp}, {30'h0, bq.pop_front()});
    end
    if (o_rvalid === 1'b1 && i_rready === 1'b1) begin
      if (rq.size() == 0) begin
        check("read unexpected", 32'h0000_0001, 32'h0000_0000);
      end else begin
        e = rq.pop_front();
        check("rresp", {30'h0, o_rresp}, {30'h0, e.r});
        if (e.k) check("rdata", o_rdata, e.d);
      end
    end
  end

  initial begin
    logic [31:0] mc, op, pr, ac, fl, rp;
    logic [15:0] sv, r;
    logic [15:0] incs[6];
    logic        v;
    incs = '{16'h7FFF, 16'hFFFF, 16'hFFFE, 16'h0000, 16'h1234, 16'h8000};
    seed = 4729;
    fail_count = 0;
    checks = 0;
    i_rst_n = 1'b0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // every register comes out of reset cleared
    for (int k = 0; k < 9; k++)
      bus_rd(8'(k * 4), MSI_RST_WORD, MSI_RESP_OKAY, 1'b1);
    // every shift code, boundary operands on the first two
    for (int pm = 0; pm < 10; pm++) begin
      mc = (pm < 2) ? 32'h8000_0000 : $random(seed);
      op = (pm < 2) ? 32'hFFFF_FFFF : $random(seed);
      ac = $random(seed);
      rp = {16'h0000, 16'($random(seed)) | 16'h0001};
      fl = {28'h000_0000, 4'($random(seed))};
      pr = exp_prod(mc, op, 4'(pm));
      bus_wr(MSI_OFS_MCAND, mc, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_OPLONG, op, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_MODE, 32'h0000_0100 | 32'(pm), MSI_RESP_OKAY);
      bus_wr(MSI_OFS_REPEAT, rp, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_ACC, ac, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_FLAGS, fl | 32'h0000_0010, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_ISSUE, {16'h0000, MSI_OPC_MUL}, MSI_RESP_OKAY);
      bus_rd(MSI_OFS_PRODUCT, pr, MSI_RESP_OKAY,
             1'b1);
      bus_rd(MSI_OFS_REPEAT, 32'h0000_0000, MSI_RESP_OKAY, 1'b1);
      bus_rd(MSI_OFS_ACC, ac, MSI_RESP_OKAY, 1'b1);
      bus_rd(MSI_OFS_FLAGS, fl, MSI_RESP_OKAY, 1'b1);
    end
    // multiply outside object mode one is refused
    bus_wr(MSI_OFS_MODE, 32'h0000_0000, MSI_RESP_OKAY);
    bus_wr(MSI_OFS_MCAND, 32'h1234_5678, MSI_RESP_OKAY);
    bus_wr(MSI_OFS_REPEAT, 32'h0000_0007, MSI_RESP_OKAY);
    bus_wr(MSI_OFS_ISSUE, {16'h0000, MSI_OPC_MUL}, MSI_RESP_OKAY);
    bus_rd(MSI_OFS_PRODUCT, pr, MSI_RESP_OKAY, 1'b1);
    bus_rd(MSI_OFS_FLAGS, fl | 32'h0000_0010, MSI_RESP_OKAY, 1'b1);
    bus_rd(MSI_OFS_REPEAT, 32'h0000_0007, MSI_RESP_OKAY, 1'b1);
    // increment corner values, overflow flag preset both ways
    for (int i = 0; i < 6; i++) begin
      sv = incs[i];
      v = i[0];
      r = sv + 16'h0001;
      bus_wr(MSI_OFS_OPSHORT, {16'h0000, sv}, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_FLAGS, {27'h0, 1'b1, v, 3'h0}, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_REPEAT, 32'h0000_0003, MSI_RESP_OKAY);
      bus_wr(MSI_OFS_ISSUE, {16'h0000, MSI_OPC_INC_HI, 8'($random(seed))},
             MSI_RESP_OKAY);
      bus_rd(MSI_OFS_OPSHORT, {16'h0000, r}, MSI_RESP_OKAY, 1'b1);
      fl = {28'h000_0000, (sv == MSI_SHORT_MAX_P) | v,
            sv == MSI_SHORT_ONES, r == 16'h0000, r[15]};
      bus_rd(MSI_OFS_FLAGS, fl, MSI_RESP_OKAY,
             1'b1);
      bus_rd(MSI_OFS_REPEAT, 32'h0000_0000, MSI_RESP_OKAY, 1'b1);
    end
    // read-only product, unmapped place, write-only issue port
    bus_wr(MSI_OFS_PRODUCT, $random(seed), MSI_RESP_SLVERR);
    bus_rd(MSI_OFS_PRODUCT, pr, MSI_RESP_OKAY, 1'b1);
    bus_rd(8'h24, 32'h0000_0000, MSI_RESP_SLVERR, 1'b0);
    bus_wr(8'h24, 32'h0000_0001, MSI_RESP_SLVERR);
    bus_rd(MSI_OFS_ISSUE, 32'h0000_0000, MSI_RESP_OKAY, 1'b1);
    repeat (2) @(posedge i_clk);
    if (rq.size() != 0 || bq.size() != 0) fail_count++;
    conclude();
  end
endmodule
